/* design/mpa_pkg.sv */
// package: register map, field layout and state codes of the negotiation block
package mpa_pkg;
  localparam int ADDR_W = 8;
  localparam int TIMER_W = 20;
  localparam int ABIL_W = 16;
  // byte offsets on the register bus
  localparam logic [7:0] OFF_SD_SETUP = 8'h00;
  localparam logic [7:0] OFF_LAYER_STATE = 8'h04;
  localparam logic [7:0] OFF_NEG_SETUP = 8'h08;
  localparam logic [7:0] OFF_NEG_TIMER = 8'h0c;
  localparam logic [7:0] OFF_NEG_REPORT = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // sig_detect_setup bits
  localparam int SD_USE_BIT = 0;
  localparam int SD_SENSE_BIT = 1;
  // negotiation_setup bits
  localparam int NS_ON_BIT = 0;
  localparam int NS_REDO_BIT = 1;
  localparam int NS_SWPRI_BIT = 2;
  localparam int NS_HYS_BIT = 3;
  localparam int NS_OFFER_LSB = 16;
  // negotiation_state_report bits
  localparam int NR_PAGE_BIT = 0;
  localparam int NR_EXCH_BIT = 1;
  localparam int NR_DONE_BIT = 2;
  localparam int NR_SYNC_BIT = 3;
  localparam int NR_STATE_LSB = 4;
  localparam int NR_PARTNER_LSB = 16;
  // irq status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_PAGE = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_LOSS = 2;
  // reset values
  localparam logic [TIMER_W-1:0] TIMER_RST = 20'h0000a;
  localparam logic [ABIL_W-1:0] OFFER_RST = 16'h0001;
  typedef enum logic [2:0] {
    AN_IDLE = 3'h0,
    AN_SEND = 3'h1,
    AN_DETECT = 3'h3,
    AN_LINK_OK = 3'h2
  } mpa_an_state_t;
endpackage : mpa_pkg

/* design/mpa_sync3.sv */
// three-stage synchroniser that commits a change once stages two and three agree
`timescale 1ns/10ps
module mpa_sync3 (
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic [2:0] st;
    logic q;
  } mpa_sync_t;
  mpa_sync_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.st = {s_reg.st[1:0], din};
    if (s_reg.st[1] == s_reg.st[2]) begin
      s_next.q = s_reg.st[2];
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign dout = s_reg.q;
endmodule : mpa_sync3

/* design/mpa_timer.sv */
// down counter that pulses once a loaded period has elapsed
`timescale 1ns/10ps
module mpa_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic run,
  input wire logic [mpa_pkg::TIMER_W-1:0] period,
  output logic expired
);
  typedef struct packed {
    logic [mpa_pkg::TIMER_W-1:0] cnt;
    logic busy;
  } mpa_tmr_t;
  mpa_tmr_t t_reg, t_next;
  // a zero period is taken as one cycle so the state machine never stalls
  always_comb begin
    t_next = t_reg;
    expired = 1'b0;
    if (start) begin
      t_next.busy = 1'b1;
      t_next.cnt = (period == '0) ? mpa_pkg::TIMER_W'(1) : period;
    end else if (!run) begin
      t_next.busy = 1'b0;
    end else if (t_reg.busy) begin
      if (t_reg.cnt <= mpa_pkg::TIMER_W'(1)) begin
        expired = 1'b1;
        t_next.busy = 1'b0;
      end else begin
        t_next.cnt = t_reg.cnt - mpa_pkg::TIMER_W'(1);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end
endmodule : mpa_timer

/* design/mpa_autoneg.sv */
// signal detect, block-lock watch and hardware-assisted negotiation with a wishbone slave
// How it works
// RQ1 - signal-detect pin is ignored unless sig_detect_use is one
// RQ2 - signal counts as present only when the pin equals sig_detect_level_sense
// RQ3 - in use and no signal present restarts negotiation
// RQ4 - read-only coding_aligned_status bit mirrors block lock
// RQ5 - negotiation runs only while negotiation_on is one
// RQ6 - writing negotiation_redo_pulse restarts negotiation from its start
// RQ7 - waiting periods are timed by a programmable link-timer field
// RQ8 - software should keep software_priority_choice at one
// RQ9 - local_offer_word is sent as our ability word
// RQ10 - partner word is stored readable and a sticky page flag set
// RQ11 - after exchange enter idle-detect and set exchange_finished_flag
// RQ12 - software then applies resets and speed from the negotiated abilities
// RQ13 - idle-detect moves to link-ok one link-timer period later
// RQ14 - negotiation_done rises when link-ok is reached
// RQ15 - without hysteresis lock loss fails sync and restarts at once
// RQ16 - with hysteresis fail only after lock low a whole link-timer period
// RQ17 - alignment_loss_delay_on resets to zero
// RQ18 - redo pulse clears itself once taken
// RQ19 - page flag stays set until written one, surviving restarts
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module mpa_autoneg (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [mpa_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic sig_detect_pin,
  input wire logic block_lock,
  input wire logic partner_valid,
  input wire logic [mpa_pkg::ABIL_W-1:0] partner_word,
  output logic [mpa_pkg::ABIL_W-1:0] tx_offer_word,
  output logic tx_offer_valid,
  output logic link_ok,
  output logic irq
);
  typedef struct packed {
    logic sd_use;
    logic sd_sense;
    logic neg_on;
    logic redo;
    logic sw_pri;
    logic hys_on;
    logic [mpa_pkg::ABIL_W-1:0] offer;
    logic [mpa_pkg::TIMER_W-1:0] timer;
    logic [mpa_pkg::ABIL_W-1:0] partner;
    logic exch_fin;
    logic done;
    logic sync_ok;
    mpa_pkg::mpa_an_state_t st;
    logic [mpa_pkg::IRQ_W-1:0] irq_stat;
    logic [mpa_pkg::IRQ_W-1:0] irq_mask;
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic [mpa_pkg::ABIL_W-1:0] tx_word;
    logic tx_val;
    logic lnk;
    logic irq_q;
    logic hys_run;
  } mpa_state_t;

  mpa_state_t r_reg, r_next;
  logic sd_sync;
  logic lock_sync;
  logic tmr_start;
  logic tmr_run;
  logic tmr_exp;
  logic hys_exp;
  logic sig_present;
  logic restart;
  logic lock_fail;
  logic req;
  logic wr;
  logic [1:0] pin_raw;
  logic [1:0] pin_sync;

  // pin inputs cross into clk through four flops each; bit 0 detect, bit 1 lock
  assign pin_raw = {block_lock, sig_detect_pin};
  for (genvar i = 0; i < 2; i++) begin : g_pin_sync
    mpa_sync3 u_sync (
      .clk(clk),
      .nrst(nrst),
      .din(pin_raw[i]),
      .dout(pin_sync[i])
    );
  end
  assign sd_sync = pin_sync[0];
  assign lock_sync = pin_sync[1];

  // one timer paces the state machine, a second times the lock-loss hold-off
  mpa_timer u_an_timer (
    .clk(clk),
    .nrst(nrst),
    .start(tmr_start),
    .run(tmr_run),
    .period(r_reg.timer),
    .expired(tmr_exp)
  );
  mpa_timer u_hys_timer (
    .clk(clk),
    .nrst(nrst),
    .start(lock_sync == 1'b0 && !r_reg.hys_run),
    .run(!lock_sync),
    .period(r_reg.timer),
    .expired(hys_exp)
  );

  function automatic logic [3:0] bytes_of(input logic [3:0] sel);
    bytes_of = sel;
  endfunction : bytes_of

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  always_comb begin
    logic [31:0] w;
    logic [mpa_pkg::IRQ_W-1:0] ev;
    logic [mpa_pkg::IRQ_W-1:0] clr;
    w = '0;
    ev = '0;
    clr = '0;
    r_next = r_reg;
    tmr_start = 1'b0;
    req = wb_cyc_i && wb_stb_i && !r_reg.ack && !r_reg.err;
    wr = req && wb_we_i;

    sig_present = !r_reg.sd_use || (sd_sync == r_reg.sd_sense); // RQ1 RQ2
    // lock loss fails sync at once, or after a full timer period of low lock
    // with hysteresis a failed sync keeps negotiation held until lock returns
    lock_fail = r_reg.hys_on ? (hys_exp || (!r_reg.sync_ok && !lock_sync)) : !lock_sync; // RQ15 RQ16
    restart = !sig_present || lock_fail || r_reg.redo; // RQ3 RQ6

    r_next.hys_run = !lock_sync;
    if (lock_fail) begin
      r_next.sync_ok = 1'b0; // RQ15 RQ16
    end else if (lock_sync) begin
      r_next.sync_ok = 1'b1;
    end

    // negotiation state machine
    tmr_run = r_reg.st == mpa_pkg::AN_DETECT;
    if (!r_reg.neg_on) begin // RQ5
      r_next.st = mpa_pkg::AN_IDLE;
      r_next.exch_fin = 1'b0;
      r_next.done = 1'b0;
    end else if (restart) begin
      r_next.st = mpa_pkg::AN_SEND; // RQ6
      r_next.exch_fin = 1'b0;
      r_next.done = 1'b0;
      r_next.redo = 1'b0; // RQ18
    end else begin
      unique case (r_reg.st)
        mpa_pkg::AN_IDLE: begin
          r_next.st = mpa_pkg::AN_SEND;
        end
        mpa_pkg::AN_SEND: begin
          if (partner_valid) begin
            r_next.partner = partner_word; // RQ10
            ev[mpa_pkg::IRQ_PAGE] = 1'b1; // RQ10
            r_next.exch_fin = 1'b1; // RQ11
            r_next.st = mpa_pkg::AN_DETECT; // RQ11
            tmr_start = 1'b1; // RQ7
          end
        end
        mpa_pkg::AN_DETECT: begin
          if (tmr_exp) begin
            r_next.st = mpa_pkg::AN_LINK_OK; // RQ13
            r_next.done = 1'b1; // RQ14
            ev[mpa_pkg::IRQ_DONE] = 1'b1;
          end
        end
        mpa_pkg::AN_LINK_OK: begin
          r_next.done = 1'b1; // RQ14
        end
      endcase
    end
    if (lock_fail && r_reg.sync_ok) begin
      ev[mpa_pkg::IRQ_LOSS] = 1'b1;
    end

    r_next.tx_word = r_reg.offer; // RQ9
    r_next.tx_val = r_reg.neg_on && r_next.st == mpa_pkg::AN_SEND;
    r_next.lnk = r_next.st == mpa_pkg::AN_LINK_OK;

    // wishbone classic slave: one-cycle answer, ack dropped the cycle after
    r_next.ack = 1'b0;
    r_next.err = 1'b0;
    r_next.rdata = '0;
    if (req) begin
      r_next.ack = 1'b1;
      unique case (wb_adr_i)
        mpa_pkg::OFF_SD_SETUP: begin
          w[mpa_pkg::SD_USE_BIT] = r_reg.sd_use;
          w[mpa_pkg::SD_SENSE_BIT] = r_reg.sd_sense;
          if (wr) begin
            w = merge(w, wb_dat_i, bytes_of(wb_sel_i));
            r_next.sd_use = w[mpa_pkg::SD_USE_BIT];
            r_next.sd_sense = w[mpa_pkg::SD_SENSE_BIT];
          end
        end
        mpa_pkg::OFF_LAYER_STATE: begin
          w[0] = lock_sync; // RQ4
        end
        mpa_pkg::OFF_NEG_SETUP: begin
          w[mpa_pkg::NS_ON_BIT] = r_reg.neg_on;
          w[mpa_pkg::NS_REDO_BIT] = r_reg.redo;
          w[mpa_pkg::NS_SWPRI_BIT] = r_reg.sw_pri; // RQ8
          w[mpa_pkg::NS_HYS_BIT] = r_reg.hys_on;
          w[mpa_pkg::NS_OFFER_LSB +: mpa_pkg::ABIL_W] = r_reg.offer;
          if (wr) begin
            w = merge(w, wb_dat_i, bytes_of(wb_sel_i));
            r_next.neg_on = w[mpa_pkg::NS_ON_BIT];
            r_next.redo = w[mpa_pkg::NS_REDO_BIT]; // RQ6
            r_next.sw_pri = w[mpa_pkg::NS_SWPRI_BIT];
            r_next.hys_on = w[mpa_pkg::NS_HYS_BIT];
            r_next.offer = w[mpa_pkg::NS_OFFER_LSB +: mpa_pkg::ABIL_W]; // RQ9
          end
        end
        mpa_pkg::OFF_NEG_TIMER: begin
          w[mpa_pkg::TIMER_W-1:0] = r_reg.timer;
          if (wr) begin
            w = merge(w, wb_dat_i, bytes_of(wb_sel_i));
            r_next.timer = w[mpa_pkg::TIMER_W-1:0]; // RQ7
          end
        end
        mpa_pkg::OFF_NEG_REPORT: begin
          w[mpa_pkg::NR_PAGE_BIT] = r_reg.irq_stat[mpa_pkg::IRQ_PAGE]; // RQ19
          w[mpa_pkg::NR_EXCH_BIT] = r_reg.exch_fin;
          w[mpa_pkg::NR_DONE_BIT] = r_reg.done;
          w[mpa_pkg::NR_SYNC_BIT] = r_reg.sync_ok;
          w[mpa_pkg::NR_STATE_LSB +: 3] = r_reg.st;
          w[mpa_pkg::NR_PARTNER_LSB +: mpa_pkg::ABIL_W] = r_reg.partner; // RQ10
        end
        mpa_pkg::OFF_IRQ_STATUS: begin
          w[mpa_pkg::IRQ_W-1:0] = r_reg.irq_stat;
          if (wr && wb_sel_i[0]) begin
            clr = wb_dat_i[mpa_pkg::IRQ_W-1:0];
          end
        end
        mpa_pkg::OFF_IRQ_MASK: begin
          w[mpa_pkg::IRQ_W-1:0] = r_reg.irq_mask;
          if (wr && wb_sel_i[0]) begin
            r_next.irq_mask = wb_dat_i[mpa_pkg::IRQ_W-1:0];
          end
        end
        default: begin
          r_next.ack = 1'b0;
          r_next.err = 1'b1;
        end
      endcase
      if (!wb_we_i) begin
        r_next.rdata = w;
      end
    end

    // sticky events: a new event wins over a same-cycle clear
    r_next.irq_stat = (r_reg.irq_stat & ~clr) | ev; // RQ19
    r_next.irq_q = |(r_next.irq_stat & r_next.irq_mask);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.timer <= mpa_pkg::TIMER_RST;
      r_reg.offer <= mpa_pkg::OFFER_RST;
      r_reg.sw_pri <= 1'b1;
      r_reg.hys_on <= 1'b0; // RQ17
      r_reg.st <= mpa_pkg::AN_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_dat_o = r_reg.rdata;
  assign wb_ack_o = r_reg.ack;
  assign wb_err_o = r_reg.err;
  assign tx_offer_word = r_reg.tx_word;
  assign tx_offer_valid = r_reg.tx_val;
  assign link_ok = r_reg.lnk;
  assign irq = r_reg.irq_q;
endmodule : mpa_autoneg

/* bench/mpa_autoneg_asserts.sv */
// checker: bus and negotiation timing relations seen at the block ports
`timescale 1ns/10ps
module mpa_autoneg_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic block_lock,
  input wire logic partner_valid,
  input wire logic [mpa_pkg::ABIL_W-1:0] tx_offer_word,
  input wire logic tx_offer_valid,
  input wire logic link_ok,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // saturating count of cycles with lock low; 40 is past any timer the bench sets
  logic [5:0] low_reg;
  logic [5:0] low_next;
  always_comb begin
    low_next = block_lock ? 6'h00 : low_reg + {5'h00, low_reg != 6'h3f};
  end
  always_ff @(posedge clk) begin
    low_reg <= nrst ? low_next : 6'h00;
  end
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
  property p_ack_time; $rose(wb_cyc_i && wb_stb_i) |=> (wb_ack_o || wb_err_o); endproperty
  a_ack_time: assert property (p_ack_time) else $error("bus answer late");
  property p_ack_cause; (wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_one_answer; !(wb_ack_o && wb_err_o); endproperty
  a_one_answer: assert property (p_one_answer) else $error("ack and err together");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_offer_hold; tx_offer_valid && $past(tx_offer_valid) |-> $stable(tx_offer_word); endproperty
  a_offer_hold: assert property (p_offer_hold) else $error("offer word moved");
  property p_exch_leave; $fell(tx_offer_valid) |-> $past(partner_valid); endproperty
  a_exch_leave: assert property (p_exch_leave) else $error("send left without answer");
  property p_done_after; $rose(link_ok) |-> !tx_offer_valid && $past(!tx_offer_valid, 2); endproperty
  a_done_after: assert property (p_done_after) else $error("link ok from send");
  property p_lock_loss; low_reg >= 6'd40 |-> !link_ok; endproperty
  a_lock_loss: assert property (p_lock_loss) else $error("link kept lock lost");
  c_link: cover property ($rose(link_ok));
  c_err: cover property (wb_err_o);
  c_irq: cover property ($rose(irq));
endmodule : mpa_autoneg_asserts
bind mpa_autoneg mpa_autoneg_asserts mpa_autoneg_asserts_inst (.clk(clk), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .block_lock(block_lock), .partner_valid(partner_valid),
  .tx_offer_word(tx_offer_word), .tx_offer_valid(tx_offer_valid), .link_ok(link_ok),
  .irq(irq));

/* bench/mpa_phy_model.sv */
// link partner: answers the offer after a set lag with a fixed ability word
`timescale 1ns/10ps
module mpa_phy_model #(
  parameter logic [15:0] REPLY = 16'h5a5a
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tx_offer_valid,
  input wire logic [3:0] lag,
  output logic partner_valid,
  output logic [15:0] partner_word
);
  logic [3:0] wait_reg;
  // word toggles outside the answer so a stale sample never looks right
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wait_reg <= 4'h0;
      partner_valid <= 1'b0;
      partner_word <= 16'h0f0f;
    end else if (tx_offer_valid && wait_reg >= lag) begin
      partner_valid <= 1'b1;
      partner_word <= REPLY;
    end else begin
      wait_reg <= tx_offer_valid ? wait_reg + 4'h1 : 4'h0;
      partner_valid <= 1'b0;
      partner_word <= ~partner_word;
    end
  end
endmodule : mpa_phy_model

/* bench/test_multiport_pcs_autoneg.sv */
// testbench: register bus driven sequences over negotiation, detect and lock
`timescale 1ns/10ps
module test_multiport_pcs_autoneg;
  logic clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, sig_detect_pin;
  logic block_lock, partner_valid, tx_offer_valid, link_ok, irq, e;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] partner_word, tx_offer_word;
  logic [3:0] lag;
  int compares, miscompares, cycles, n1, n2;
  mpa_autoneg mpa_autoneg_inst (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .sig_detect_pin(sig_detect_pin), .block_lock(block_lock),
    .partner_valid(partner_valid), .partner_word(partner_word),
    .tx_offer_word(tx_offer_word), .tx_offer_valid(tx_offer_valid), .link_ok(link_ok),
    .irq(irq));
  mpa_phy_model mpa_phy_model_inst (.clk(clk), .nrst(nrst), .tx_offer_valid(tx_offer_valid),
    .lag(lag), .partner_valid(partner_valid), .partner_word(partner_word));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    $display("counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] mask);
    wb(1'b0, a, 32'h0);
    check(what, q & mask, exp);
  endtask : rc
  // counts from entry to idle-detect until link up, so the partner lag drops out
  task automatic neg(output int n);
    n = 0;
    while (tx_offer_valid !== 1'b1) @(posedge clk);
    check("offer", {16'h0, tx_offer_word}, 32'habcd);
    while (tx_offer_valid === 1'b1) @(posedge clk);
    while (link_ok !== 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask : neg
  task automatic down(output int n);
    n = 0;
    while (link_ok === 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask : down
  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, lag} <= '0;
    sig_detect_pin <= 1'b1;
    block_lock <= 1'b1;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rc("setup", 8'h08, 32'h00010004, '1);
    rc("timer", 8'h0c, 32'h0000000a, '1);
    rc("aligned", 8'h04, 32'h1, '1);
    wb(1'b0, 8'h1c, 32'h0);
    check("unmapped", {31'h0, e}, 32'h1);
    check("idle", {31'h0, tx_offer_valid}, 32'h0);
    $display("test reset done");
    wb(1'b1, 8'h0c, 32'h4);
    wb(1'b1, 8'h08, 32'habcd0005);
    neg(n1);
    rc("report", 8'h10, 32'h5a5a002f, '1);
    rc("status", 8'h14, 32'h3, '1);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wb(1'b1, 8'h18, 32'h3);
    repeat (2) @(posedge clk);
    check("irq_on", {31'h0, irq}, 32'h1);
    $display("test negotiation done");
    wb(1'b1, 8'h0c, 32'hc);
    lag <= 4'hf;
    wb(1'b1, 8'h08, 32'habcd0007);
    rc("restart", 8'h10, 32'h11, 32'h71);
    rc("redo_clear", 8'h08, 32'habcd0005, '1);
    neg(n2);
    check("timer_step", n2 - n1, 32'h8);
    wb(1'b1, 8'h14, 32'h3);
    repeat (2) @(posedge clk);
    check("irq_off", {31'h0, irq}, 32'h0);
    $display("test restart done");
    lag <= 4'h0;
    sig_detect_pin <= 1'b0;
    repeat (10) @(posedge clk);
    check("sd_off", {31'h0, link_ok}, 32'h1);
    wb(1'b1, 8'h00, 32'h1);
    repeat (10) @(posedge clk);
    check("sd_level", {31'h0, link_ok}, 32'h1);
    sig_detect_pin <= 1'b1;
    down(n1);
    check("sd_loss", {31'h0, n1 < 12}, 32'h1);
    sig_detect_pin <= 1'b0;
    neg(n1);
    $display("test signal detect done");
    block_lock <= 1'b0;
    down(n1);
    check("lock_loss", {31'h0, n1 < 12}, 32'h1);
    rc("aligned_low", 8'h04, 32'h0, 32'h1);
    rc("loss_flag", 8'h14, 32'h4, 32'h4);
    block_lock <= 1'b1;
    neg(n1);
    wb(1'b1, 8'h08, 32'habcd000d);
    block_lock <= 1'b0;
    repeat (6) @(posedge clk);
    block_lock <= 1'b1;
    repeat (10) @(posedge clk);
    check("hys_short", {31'h0, link_ok}, 32'h1);
    block_lock <= 1'b0;
    down(n1);
    check("hys_long", {31'h0, n1 >= 12}, 32'h1);
    repeat (30) @(posedge clk);
    check("hys_held", {31'h0, link_ok}, 32'h0);
    $display("test block lock done");
    close_out();
  end
endmodule : test_multiport_pcs_autoneg
